// [src/psc_port_stats.sv]
// Per-port statistics counter bank with packed counter memory and wrap reporting.
// Functional notes
// RQ1: Separate counter set per port, CPU readable.
// RQ2: Counters roll over to zero, never saturate.
// RQ3: Any counter wrap raises CPU interrupt.
// RQ4: MAC events, except filtering and delay discards.
// RQ5: 64-bit report: wrap flags, other status.
// RQ6: Counter found by address plus field code.
// RQ7: Low wide field uses bits 23..0.
// RQ8: High narrow field uses bits 31..24.
// RQ9: Middle narrow field uses bits 23..16.
// RQ10: Half-word fields use 15..0 and 31..16.
// RQ11: Flags 0-4 are transmit counters.
// RQ12: Flags 5-11 are receive counters.
// RQ13: Flags 12-15 at addresses 8 and 9.
// RQ14: Flags 16-19 are size histogram bins.
// RQ15: Flags 20-29 are error and discard counters.
// RQ16: Flag set on wrap, cleared after delivery.
`timescale 1ns/1ps
module psc_port_stats
  import psc_pkg::*;
#(
  parameter int NUM_PORTS = 5,
  parameter int BYTE_W    = 12,
  parameter int PORT_W    = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
) (
  input  wire logic                            core_clk,     // System clock
  input  wire logic                            arst_n,       // Asynchronous reset, active low
  input  wire logic [NUM_PORTS*MAC_EVT_W-1:0]  mac_evt,      // MAC event pulses, 28 per port
  input  wire logic [NUM_PORTS-1:0]            qm_filter,    // Queue manager filtering pulse
  input  wire logic [NUM_PORTS-1:0]            bm_delay,     // Buffer manager delay discard pulse
  input  wire logic [NUM_PORTS*BYTE_W-1:0]     tx_bytes,     // Bytes of the frame sent
  input  wire logic [NUM_PORTS*BYTE_W-1:0]     rx_bytes,     // Bytes of the frame received
  input  wire logic                            rd_en,        // CPU counter read request
  input  wire logic [PORT_W-1:0]               rd_port,      // Port to read
  input  wire logic [ADDR_W-1:0]               rd_addr,      // Counter word address
  output logic [WORD_W-1:0]                    rd_data,      // Counter word read back
  output logic                                 rd_valid,     // Read data valid pulse
  input  wire logic [OTHER_W-1:0]              other_status, // Upper report status bits
  output logic                                 rpt_valid,    // Wrap report offered
  input  wire logic                            rpt_ready,    // Command block takes report
  output logic [RPT_W-1:0]                     rpt_data,     // Wrap report word
  output logic [PORT_W-1:0]                    rpt_port,     // Port of the report
  output logic                                 wrap_irq      // Wrap interrupt to CPU
);

  typedef enum logic {RPT_IDLE, RPT_SEND} psc_rpt_e;

  logic [WORD_W-1:0] cnt_mem   [NUM_PORTS][MEM_WORDS];
  logic [WORD_W-1:0] next_mem  [NUM_PORTS][MEM_WORDS];
  logic [WORD_W-1:0] fld_val   [NUM_PORTS][NUM_CNT];
  logic [WORD_W-1:0] fld_mask  [NUM_PORTS][NUM_CNT];
  logic [FLAG_W-1:0] evt_all   [NUM_PORTS];
  logic [FLAG_W-1:0] wrap_now  [NUM_PORTS];
  logic [FLAG_W-1:0] wrap_flag [NUM_PORTS];
  logic [FLAG_W-1:0] next_flag [NUM_PORTS];
  logic [NUM_PORTS-1:0] pending;
  logic [NUM_PORTS-1:0] next_pending;
  psc_rpt_e          rpt_state;
  psc_rpt_e          next_rpt_state;
  logic              rpt_accept;
  logic [PORT_W-1:0] pick;
  logic              rd_in_range;

  // Lowest pending port wins; a busy low port can delay reports of higher ports.
  function automatic logic [PORT_W-1:0] first_set(input logic [NUM_PORTS-1:0] v);
    logic [PORT_W-1:0] r;
    r = '0;
    for (int i = NUM_PORTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = PORT_W'(i);
      end
    end
    return r;
  endfunction

  genvar gp, gc;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      // Filtering and delay discards come from outside the MAC.
      assign evt_all[gp] = {mac_evt[gp*MAC_EVT_W+MAC_EVT_W-1],                   // [RQ4]
                            bm_delay[gp],
                            qm_filter[gp],
                            mac_evt[gp*MAC_EVT_W +: FLAG_FILTER]};
      for (gc = 0; gc < NUM_CNT; gc++) begin : g_cnt
        logic [BYTE_W-1:0] inc;
        if (gc == FLAG_TX_BYTES) begin : g_txb
          assign inc = tx_bytes[gp*BYTE_W +: BYTE_W];                           // [RQ11]
        end else if (gc == FLAG_RX_BYTES || gc == FLAG_TOT_BYTES) begin : g_rxb
          assign inc = rx_bytes[gp*BYTE_W +: BYTE_W];                           // [RQ12]
        end else begin : g_one
          assign inc = BYTE_W'(1);
        end
        // Address and code tables place every counter in its word.
        psc_field_inc #(
          .INC_W (BYTE_W)
        ) u_fld (
          .word   (cnt_mem[gp][CNT_ADDR[gc]]),                                  // [RQ6]
          .code   (CNT_CODE[gc]),                                               // [RQ7] [RQ8] [RQ9] [RQ10]
          .en     (evt_all[gp][gc]),
          .inc    (inc),
          .placed (fld_val[gp][gc]),
          .mask   (fld_mask[gp][gc]),
          .wrap   (wrap_now[gp][gc])                                            // [RQ13] [RQ14] [RQ15]
        );
      end
    end
  endgenerate

  // Fields of one word are disjoint, so all their updates merge in one cycle.
  always_comb begin
    logic [WORD_W-1:0] m;
    logic [WORD_W-1:0] v;
    m = '0;
    v = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int w = 0; w < MEM_WORDS; w++) begin
        m = '0;
        v = '0;
        for (int c = 0; c < NUM_CNT; c++) begin
          if (CNT_ADDR[c] == ADDR_W'(w)) begin
            m = m | fld_mask[p][c];
            v = v | fld_val[p][c];
          end
        end
        next_mem[p][w] = (cnt_mem[p][w] & ~m) | v;                              // [RQ1]
      end
    end
  end

  assign rpt_accept = (rpt_state == RPT_SEND) && rpt_ready;
  assign rpt_valid  = (rpt_state == RPT_SEND);

  // A wrap in the same cycle as the delivery of its flag survives the clear.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (rpt_accept && rpt_port == PORT_W'(p)) begin
        next_flag[p] = (wrap_flag[p] & ~rpt_data[FLAG_W-1:0]) | wrap_now[p];    // [RQ16]
      end else begin
        next_flag[p] = wrap_flag[p] | wrap_now[p];                              // [RQ16]
      end
      next_pending[p] = |next_flag[p];
      pending[p]      = |wrap_flag[p];
    end
  end

  assign pick = first_set(pending);

  always_comb begin
    next_rpt_state = rpt_state;
    unique case (rpt_state)
      RPT_IDLE: begin
        if (|pending) begin
          next_rpt_state = RPT_SEND;
        end
      end
      RPT_SEND: begin
        if (rpt_ready) begin
          next_rpt_state = RPT_IDLE;
        end
      end
    endcase
  end

  assign rd_in_range = (rd_port < PORT_W'(NUM_PORTS - 1)) || (rd_port == PORT_W'(NUM_PORTS - 1));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        wrap_flag[p] <= FLAG_RESET;
        for (int w = 0; w < MEM_WORDS; w++) begin
          cnt_mem[p][w] <= CNT_RESET;
        end
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        wrap_flag[p] <= next_flag[p];
        for (int w = 0; w < MEM_WORDS; w++) begin
          cnt_mem[p][w] <= next_mem[p][w];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rpt_state <= RPT_IDLE;
      rpt_data  <= '0;
      rpt_port  <= '0;
      wrap_irq  <= 1'b0;
    end else begin
      rpt_state <= next_rpt_state;
      wrap_irq  <= |next_pending;                                               // [RQ3]
      if (rpt_state == RPT_IDLE && |pending) begin
        rpt_port <= pick;
        rpt_data <= {other_status, wrap_flag[pick]};                            // [RQ5]
      end
    end
  end

  // Reads return the word as it stood before any update in the same cycle.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= rd_in_range ? cnt_mem[rd_port][rd_addr] : '0;                // [RQ1]
      end
    end
  end

endmodule

// [src/psc_pkg.sv]
// Package with the counter-memory layout and field codes for the port statistics bank.
package psc_pkg;

  localparam int NUM_CNT   = 30;
  localparam int MEM_WORDS = 16;
  localparam int ADDR_W    = 4;
  localparam int WORD_W    = 32;
  localparam int RPT_W     = 64;
  localparam int FLAG_W    = 30;
  localparam int OTHER_W   = 34;
  localparam int MAC_EVT_W = 28;

  // Wrap-flag indices that need special event sources or byte increments.
  localparam int FLAG_TX_BYTES  = 0;
  localparam int FLAG_RX_BYTES  = 5;
  localparam int FLAG_TOT_BYTES = 7;
  localparam int FLAG_FILTER    = 27;
  localparam int FLAG_DELAY     = 28;
  localparam int FLAG_LATE      = 29;

  // Field positions inside one counter word.
  localparam logic [5:0] DWORD_LSB  = 6'h00;
  localparam logic [5:0] DWORD_W    = 6'h20;
  localparam logic [5:0] LOW24_LSB  = 6'h00;
  localparam logic [5:0] LOW24_W    = 6'h18;
  localparam logic [5:0] HIGH8_LSB  = 6'h18;
  localparam logic [5:0] HIGH8_W    = 6'h08;
  localparam logic [5:0] MID8_LSB   = 6'h10;
  localparam logic [5:0] MID8_W     = 6'h08;
  localparam logic [5:0] LOW16_LSB  = 6'h00;
  localparam logic [5:0] LOW16_W    = 6'h10;
  localparam logic [5:0] HIGH16_LSB = 6'h10;
  localparam logic [5:0] HIGH16_W   = 6'h10;

  localparam logic [WORD_W-1:0] CNT_RESET  = 32'h0;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 30'h0;

  typedef enum logic [2:0] {
    FC_DWORD,
    FC_LOW24,
    FC_HIGH8,
    FC_MID8,
    FC_LOW16,
    FC_HIGH16
  } psc_field_e;

  // Word address of each counter, indexed by wrap-flag number.
  localparam logic [ADDR_W-1:0] CNT_ADDR [NUM_CNT] = '{
    4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h6,
    4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9, 4'hA, 4'hA, 4'hB, 4'hB,
    4'hC, 4'hC, 4'hC, 4'hD, 4'hD, 4'hE, 4'hE, 4'hF, 4'hF, 4'hF
  };

  // Field code of each counter, indexed by wrap-flag number.
  localparam psc_field_e CNT_CODE [NUM_CNT] = '{
    FC_DWORD, FC_LOW24, FC_HIGH8, FC_LOW16, FC_HIGH16,
    FC_DWORD, FC_DWORD, FC_DWORD, FC_LOW24, FC_HIGH8,
    FC_LOW16, FC_HIGH16, FC_LOW24, FC_HIGH8, FC_LOW24,
    FC_HIGH8, FC_LOW16, FC_HIGH16, FC_LOW16, FC_HIGH16,
    FC_LOW16, FC_MID8, FC_HIGH8, FC_LOW16, FC_HIGH16,
    FC_LOW16, FC_HIGH16, FC_LOW16, FC_MID8, FC_HIGH8
  };

endpackage

// [src/psc_field_inc.sv]
// Increment of one packed counter field inside a 32-bit counter word.
`timescale 1ns/1ps
module psc_field_inc
  import psc_pkg::*;
#(
  parameter int INC_W = 12
) (
  input  wire logic [WORD_W-1:0] word,    // Current counter word
  input  wire psc_field_e        code,    // Size and bit-field code
  input  wire logic              en,      // Event seen this cycle
  input  wire logic [INC_W-1:0]  inc,     // Amount to add
  output logic [WORD_W-1:0]      placed,  // New field value at its position
  output logic [WORD_W-1:0]      mask,    // Bits owned by this field
  output logic                   wrap     // Field passed its all-ones value
);

  logic [5:0]  lsb;
  logic [5:0]  width;
  logic [32:0] ones;
  logic [31:0] fmask;
  logic [31:0] cur;
  logic [32:0] sum;

  always_comb begin
    unique case (code)
      FC_DWORD: begin
        lsb   = DWORD_LSB;
        width = DWORD_W;
      end
      FC_LOW24: begin
        lsb   = LOW24_LSB;
        width = LOW24_W;
      end
      FC_HIGH8: begin
        lsb   = HIGH8_LSB;
        width = HIGH8_W;
      end
      FC_MID8: begin
        lsb   = MID8_LSB;
        width = MID8_W;
      end
      FC_LOW16: begin
        lsb   = LOW16_LSB;
        width = LOW16_W;
      end
      FC_HIGH16: begin
        lsb   = HIGH16_LSB;
        width = HIGH16_W;
      end
      // Codes 6 and 7 are unused; treating them as a full word keeps the decode latch-free.
      default: begin
        lsb   = DWORD_LSB;
        width = DWORD_W;
      end
    endcase
  end

  assign ones  = (33'h1 << width) - 33'h1;
  assign fmask = ones[31:0];
  assign cur   = (word >> lsb) & fmask;
  // The carry above the field is the wrap; the stored value simply rolls over.
  assign sum    = {1'b0, cur} + {{(33-INC_W){1'b0}}, inc};               // [RQ2]
  assign wrap   = en & sum[width];
  assign placed = en ? ((sum[31:0] & fmask) << lsb) : 32'h0;
  assign mask   = en ? (fmask << lsb) : 32'h0;

endmodule

// [dv/psc_port_stats_monitor.sv]
// Assertion checker for the statistics bank ports.
`timescale 1ns/1ps
module psc_port_stats_monitor
  import psc_pkg::*;
#(
  parameter int NUM_PORTS = 5,
  parameter int PORT_W    = 3
) (
  input wire logic               core_clk,     // Clock
  input wire logic               arst_n,       // Reset, active low
  input wire logic               rd_en,        // Read request
  input wire logic               rd_valid,     // Read answer
  input wire logic [OTHER_W-1:0] other_status, // Upper status
  input wire logic               rpt_valid,    // Report offered
  input wire logic               rpt_ready,    // Report taken
  input wire logic [RPT_W-1:0]   rpt_data,     // Report word
  input wire logic [PORT_W-1:0]  rpt_port,     // Report port
  input wire logic               wrap_irq      // Wrap interrupt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_offer;
    rpt_valid && !rpt_ready;
  endsequence
  sequence s_take;
    rpt_valid && rpt_ready;
  endsequence
  rd_answer_a: assert property (rd_en |=> rd_valid) else $error("read not answered");
  rd_pulse_a: assert property (!rd_en |=> !rd_valid) else $error("stray read answer");
  rpt_hold_a: assert property (s_offer |=> rpt_valid && $stable(rpt_data) && $stable(rpt_port))
    else $error("report changed before accept");
  rpt_done_a: assert property (s_take |=> !rpt_valid) else $error("report kept after accept");
  rpt_other_a: assert property ($rose(rpt_valid) |-> rpt_data[63:30] == $past(other_status))
    else $error("upper report bits wrong");
  rpt_flags_a: assert property (rpt_valid |-> rpt_data[29:0] != 30'h0 && rpt_port < NUM_PORTS)
    else $error("empty or bad report");
  irq_pending_a: assert property (rpt_valid |-> wrap_irq) else $error("report without interrupt");
  irq_report_a: assert property (wrap_irq |-> ##[0:3] rpt_valid) else $error("interrupt without report");
endmodule
bind psc_port_stats psc_port_stats_monitor #(.NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W)) u_mon (
  .core_clk(core_clk), .arst_n(arst_n), .rd_en(rd_en), .rd_valid(rd_valid),
  .other_status(other_status), .rpt_valid(rpt_valid), .rpt_ready(rpt_ready),
  .rpt_data(rpt_data), .rpt_port(rpt_port), .wrap_irq(wrap_irq));

// [dv/psc_cmd_model.sv]
// Command block model that takes wrap reports, promptly or after a stall.
`timescale 1ns/1ps
module psc_cmd_model
  import psc_pkg::*;
#(
  parameter int PORT_W = 3
) (
  input  wire logic              core_clk,  // Clock
  input  wire logic              arst_n,    // Reset, active low
  input  wire logic              slow,      // Stall each report
  input  wire logic              rpt_valid, // Report offered
  output logic                   rpt_ready, // Report taken
  input  wire logic [RPT_W-1:0]  rpt_data,  // Report word
  input  wire logic [PORT_W-1:0] rpt_port,  // Report port
  output logic [RPT_W-1:0]       got_data,  // Last report
  output logic [PORT_W-1:0]      got_port,  // Its port
  output logic                   got        // Pulse per report
);
  logic [2:0] wait_cnt;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rpt_ready <= 1'b0;
      wait_cnt <= 3'h0;
      got <= 1'b0;
      got_data <= '0;
      got_port <= '0;
    end else begin
      got <= 1'b0;
      if (rpt_valid && rpt_ready) begin
        got <= 1'b1;
        got_data <= rpt_data;
        got_port <= rpt_port;
        rpt_ready <= 1'b0;
        wait_cnt <= 3'h0;
      end else if (rpt_valid) begin
        wait_cnt <= wait_cnt + 3'h1;
        rpt_ready <= !slow || wait_cnt == 3'h3;
      end
    end
  end
endmodule

// [dv/psc_port_stats_test.sv]
// Self-checking bench for the statistics bank.
`timescale 1ns/1ps
module psc_port_stats_test;
  import psc_pkg::*;
  localparam int NP = 5;
  logic                   core_clk = 1'b0;
  logic                   arst_n = 1'b0;
  logic [NP*28-1:0]       mac_evt = '0;
  logic [NP-1:0]          qm_filter = '0;
  logic [NP-1:0]          bm_delay = '0;
  logic [NP*12-1:0]       tx_bytes = {NP{12'h5A3}};
  logic [NP*12-1:0]       rx_bytes = {NP{12'h3C7}};
  logic                   rd_en = 1'b0;
  logic [2:0]             rd_port = 3'h0;
  logic [3:0]             rd_addr = 4'h0;
  logic [OTHER_W-1:0]     other_status = 34'h2A5C3F00F;
  logic                   slow = 1'b0;
  logic [31:0]            rd_data;
  logic                   rd_valid, rpt_valid, rpt_ready, wrap_irq, got;
  logic [63:0]            rpt_data, got_data;
  logic [2:0]             rpt_port, got_port;
  logic [31:0]            exp_mem [8][16] = '{default: '0};
  int                     error_cnt = 0;
  int                     cmp_count = 0;
  psc_port_stats #(.NUM_PORTS(NP), .BYTE_W(12), .PORT_W(3)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .mac_evt(mac_evt), .qm_filter(qm_filter),
    .bm_delay(bm_delay), .tx_bytes(tx_bytes), .rx_bytes(rx_bytes), .rd_en(rd_en),
    .rd_port(rd_port), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .other_status(other_status), .rpt_valid(rpt_valid), .rpt_ready(rpt_ready),
    .rpt_data(rpt_data), .rpt_port(rpt_port), .wrap_irq(wrap_irq));
  psc_cmd_model #(.PORT_W(3)) u_cmd (
    .core_clk(core_clk), .arst_n(arst_n), .slow(slow), .rpt_valid(rpt_valid),
    .rpt_ready(rpt_ready), .rpt_data(rpt_data), .rpt_port(rpt_port),
    .got_data(got_data), .got_port(got_port), .got(got));
  initial forever #50 core_clk = ~core_clk;
  task automatic check(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic int lsb_of(psc_field_e c);
    case (c)
      FC_HIGH8: return HIGH8_LSB;
      FC_MID8: return MID8_LSB;
      FC_HIGH16: return HIGH16_LSB;
      default: return 0;
    endcase
  endfunction
  // Holds the event lines for n edges, so n events are counted per selected port.
  task automatic fire(input logic [4:0] pm, input int f, input int n);
    logic [31:0] inc;
    inc = (f == FLAG_TX_BYTES) ? 32'h5A3 * n : n;
    if (f == FLAG_RX_BYTES || f == FLAG_TOT_BYTES) inc = 32'h3C7 * n;
    @(posedge core_clk);
    for (int p = 0; p < NP; p++) begin
      if (pm[p]) begin
        if (f == FLAG_FILTER) qm_filter[p] <= 1'b1;
        else if (f == FLAG_DELAY) bm_delay[p] <= 1'b1;
        else mac_evt[p*28+(f == FLAG_LATE ? 27 : f)] <= 1'b1;
        exp_mem[p][CNT_ADDR[f]] += inc << lsb_of(CNT_CODE[f]);
      end
    end
    repeat (n) @(posedge core_clk);
    mac_evt <= '0;
    qm_filter <= '0;
    bm_delay <= '0;
  endtask
  task automatic rd_check(input int p, input int a);
    @(posedge core_clk);
    rd_en <= 1'b1;
    rd_port <= p[2:0];
    rd_addr <= a[3:0];
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 check(rd_valid, 1'b1);
    check(rd_data, exp_mem[p][a]);
  endtask
  task automatic wait_rpt(input int p, input logic [29:0] fl);
    int n = 0;
    // Always step past the current edge, so the pulse of the previous report is not taken again.
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (got !== 1'b1 && n < 50);
    check(got, 1'b1);
    check(got_port, p);
    check(got_data, {other_status, fl});
    @(posedge core_clk);
  endtask
  task automatic t_fields;
    for (int f = 0; f < NUM_CNT; f++) fire(5'h1 << (f % NP), f, 1 + f % 3);
    for (int p = 0; p < 8; p++) for (int a = 0; a < 16; a++) rd_check(p, a);
    check(wrap_irq, 1'b0);
    $display("t_fields done");
  endtask
  // High byte fields only, so the 32-bit model sum drops the carry just as the field does.
  task automatic t_wrap(input logic [4:0] pm, input int f, input logic s);
    slow <= s;
    other_status <= ~other_status;
    fire(pm, f, 256);
    #1 check(wrap_irq, 1'b1);
    for (int p = 0; p < NP; p++) if (pm[p]) wait_rpt(p, 30'h1 << f);
    for (int p = 0; p < NP; p++) rd_check(p, CNT_ADDR[f]);
    check(wrap_irq, 1'b0);
    $display("t_wrap done");
  endtask
  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(5000 * 100);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    t_fields();
    t_wrap(5'h11, 22, 1'b1);
    t_wrap(5'h04, 29, 1'b0);
    report_and_stop();
  end
endmodule
